// ### osc_consts.vh
// Constants for the oscillator source control block
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
// Register byte offsets
`define OFF_FREQ_SEL    5'h00
`define OFF_TUNE        5'h04
`define OFF_MAN_EN      5'h08
`define OFF_SRC_REQ     5'h0C
`define OFF_STATUS      5'h10
`define OFF_AUX         5'h14
// Reset values
`define RST_TUNE        6'h00
`define RST_MAN_EN      6'h00
`define RST_FREQ_4M     4'h2
`define RST_FREQ_64M    4'h8
`define FREQ_MAX_CODE   4'h8
// Manual enable register bit positions
`define BIT_EXT_ON      7
`define BIT_HF_ON       6
`define BIT_MF_ON       5
`define BIT_LF_ON       4
`define BIT_SOSC_ON     3
`define BIT_ADC_ON      2
// Source request field positions
`define SRC_MSB         6
`define SRC_LSB         4
`define DIV_MSB         3
`define DIV_LSB         0
`define DIV_MAX_CODE    4'h9
`define DIV_4           4'h2
`define DIV_1           4'h0
// Status register bit positions
`define ST_HF_READY     7
`define ST_MF_READY     6
`define ST_HOLD         5
`define ST_PLL          4
`define ST_SRC_MSB      3
`define ST_SRC_LSB      1
// Aux register
`define BIT_SOSC_PWR    6
// Source codes
`define SRC_EXT         3'h7
`define SRC_HF          3'h6
`define SRC_LF          3'h5
`define SRC_SOSC        3'h4
`define SRC_PLL         3'h2
`define SRC_HF64        3'h0
// External oscillator mode codes
`define MODE_ECH        3'h7
`define MODE_ECM        3'h6
`define MODE_ECL        3'h5
`define MODE_HS         3'h2
`define MODE_XT         3'h1
`define MODE_LP         3'h0
// Timing counts: start-up in oscillator input edges, others in clock cycles
`define OST_COUNT       11'h400
`define HF_SETTLE_CYC   8'h40
`define TUNE_STEP_CYC   8'h10
`endif

// ### osc_startup_timer.v
// Start-up timer counting oscillator input edges before releasing operation
`timescale 1ns/1ns
`default_nettype none
`include "osc_consts.vh"
module osc_startup_timer (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_ce,
  input  wire        i_start,
  input  wire        i_crystal,
  input  wire        i_osc_in,
  output wire        o_hold
);
  reg        hold_q;
  reg        prev_q;
  reg [10:0] cnt_q;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_q <= 1'b1;
      prev_q <= 1'b0;
      cnt_q  <= 11'h000;
    end else if (i_ce) begin
      prev_q <= i_osc_in;
      if (i_start) begin
        hold_q <= i_crystal;
        cnt_q  <= 11'h000;
      end else if (hold_q && i_osc_in && !prev_q) begin
        if (cnt_q == `OST_COUNT - 11'h001) begin
          hold_q <= 1'b0;
        end
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  assign o_hold = hold_q;
endmodule // osc_startup_timer
`default_nettype wire

// ### mf_clock_divider.v
// Adaptive divider making the two medium-frequency clocks from HF ticks
`timescale 1ns/1ns
`default_nettype none
module mf_clock_divider (
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  input  wire       i_run,
  input  wire       i_tick,
  input  wire [6:0] i_half_cnt,
  output wire       o_mf_500k,
  output wire       o_mf_31k
);
  reg [6:0] cnt_q;
  reg [3:0] sub_q;
  reg       c500_q;
  reg       c31_q;

  // Half period of 500 kHz in HF ticks equals the HF rate in MHz
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= 7'h00;
      sub_q  <= 4'h0;
      c500_q <= 1'b0;
      c31_q  <= 1'b0;
    end else if (i_ce && i_run && i_tick) begin
      if (cnt_q + 7'h01 >= i_half_cnt) begin
        cnt_q  <= 7'h00;
        c500_q <= !c500_q;
        sub_q  <= sub_q + 4'h1;
        if (sub_q == 4'hF) begin
          c31_q <= !c31_q;
        end
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  assign o_mf_500k = c500_q;
  assign o_mf_31k  = c31_q;
endmodule // mf_clock_divider
`default_nettype wire

// ### oscillator_source_control.v
// Oscillator source control: registers, enables, start-up hold and clock out
// Functional notes
// - Frequency code 0..8 maps 1,2,4,8,12,16,32,48,64 MHz; 9..15 reserved.
// - Six-bit tune is two's complement; 1F max, 00 centre and reset, 20 min.
// - External force-on bit 7 keeps it running; else on peripheral request or source 111/010.
// - HF force-on bit 6 keeps HF running at selected code; else on request.
// - Bit 5 keeps 500 kHz and 31.25 kHz clocks on; else on request.
// - Bit 4 keeps the 31 kHz low-frequency oscillator on; else on request.
// - Bit 3 keeps secondary oscillator on in selected power mode; else request.
// - Bit 2 keeps converter oscillator on; else only on peripheral request.
// - Clock out runs at system clock over four when enabled and pin free.
// - Crystal modes with source 111/010 hold operation after reset or wake for 1024 input cycles.
// - External-clock mode skips the start-up timer entirely.
// - Fully static design; stopped clock keeps all state intact.
// - Source code 010 routes external oscillator through the 4x PLL.
// - Reset starts from configured source; run time changes only by requests.
// - Frequency write clears HF and MF ready; MF clock holds until settled.
// - Tune moves HF gradually without completion flag; LF is unaffected.
// - Medium clocks come from HF through a divider adapting to the code.
`timescale 1ns/1ns
`default_nettype none
`include "osc_consts.vh"
module oscillator_source_control (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_ce,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output wire        o_hreadyout,
  output wire        o_hresp,
  input  wire [2:0]  i_reset_source_cfg,
  input  wire [2:0]  i_ext_osc_mode_cfg,
  input  wire        i_clock_out_enable_cfg,
  input  wire        i_wake,
  input  wire        i_osc_in,
  input  wire        i_hf_tick,
  input  wire [5:0]  i_periph_req,
  output wire        o_external_osc_en,
  output wire        o_high_freq_internal_osc_en,
  output wire        o_mid_freq_internal_osc_en,
  output wire        o_low_freq_internal_osc_en,
  output wire        o_secondary_osc_en,
  output wire        o_converter_osc_en,
  output wire        o_secondary_osc_power_sel,
  output wire        o_pll_en,
  output wire [2:0]  o_source,
  output wire [3:0]  o_divider,
  output wire [3:0]  o_hf_freq_code,
  output reg  [6:0]  o_hf_freq_mhz,
  output wire [5:0]  o_hf_tune,
  output wire        o_hf_ready_flag,
  output wire        o_mf_ready_flag,
  output wire        o_mf_500k,
  output wire        o_mf_31k,
  output wire        o_run_hold,
  output wire        o_clkout,
  output wire        o_clkout_oe_n
);
  // Software-visible state
  reg  [3:0] hf_freq_code_q;
  reg  [5:0] hf_tune_value_q;
  reg  [5:0] man_en_q;
  reg  [2:0] new_source_request_q;
  reg  [3:0] new_divider_request_q;
  reg        sosc_pwr_q;
  // Oscillator model state
  reg  [5:0] tune_now_q;
  reg  [7:0] tune_tmr_q;
  reg  [7:0] settle_q;
  reg        hf_ready_q;
  reg        cfg_load_q;
  reg  [1:0] clkout_div_q;
  // Bus state
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg  [4:0] addr_q;
  reg  [31:0] rd_d;
  wire       addr_take;
  wire       crystal_mode;
  wire       uses_ext;
  wire       ext_en;
  wire       mf_en;
  wire       hf_en;
  wire       startup;
  wire [2:0] wr_src;
  wire [3:0] wr_div;
  wire       cfg_uses_ext;
  wire       ost_crystal;

  // Code to nominal MHz; also the 500 kHz half period in HF ticks
  always @* begin
    case (hf_freq_code_q)
      4'h0:    o_hf_freq_mhz = 7'h01;
      4'h1:    o_hf_freq_mhz = 7'h02;
      4'h2:    o_hf_freq_mhz = 7'h04;
      4'h3:    o_hf_freq_mhz = 7'h08;
      4'h4:    o_hf_freq_mhz = 7'h0C;
      4'h5:    o_hf_freq_mhz = 7'h10;
      4'h6:    o_hf_freq_mhz = 7'h20;
      4'h7:    o_hf_freq_mhz = 7'h30;
      4'h8:    o_hf_freq_mhz = 7'h40;
      default: o_hf_freq_mhz = 7'h04;
    endcase
  end

  assign addr_take   = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = !rd_pend_q;
  assign o_hresp     = 1'b0;
  assign wr_src      = i_hwdata[`SRC_MSB:`SRC_LSB];
  assign wr_div      = i_hwdata[`DIV_MSB:`DIV_LSB];
  assign startup     = cfg_load_q || i_wake;

  assign crystal_mode = (i_ext_osc_mode_cfg == `MODE_LP) ||
                        (i_ext_osc_mode_cfg == `MODE_XT) ||
                        (i_ext_osc_mode_cfg == `MODE_HS);
  assign uses_ext     = (new_source_request_q == `SRC_EXT) ||
                        (new_source_request_q == `SRC_PLL);

  // At the load edge the source register still holds its reset value,
  // so the crystal case is judged from the configuration itself there
  assign cfg_uses_ext = (i_reset_source_cfg == `SRC_EXT) ||
                        (i_reset_source_cfg == `SRC_PLL);
  assign ost_crystal  = crystal_mode && (cfg_load_q ? cfg_uses_ext : uses_ext);

  // Each oscillator runs when forced on, requested, or selected as source
  assign ext_en = man_en_q[`BIT_EXT_ON - 2] || i_periph_req[5] || uses_ext;
  assign mf_en  = man_en_q[`BIT_MF_ON - 2] || i_periph_req[3];
  assign hf_en  = man_en_q[`BIT_HF_ON - 2] || i_periph_req[4] || mf_en ||
                  (new_source_request_q == `SRC_HF) ||
                  (new_source_request_q == `SRC_HF64);
  assign o_external_osc_en           = ext_en;
  assign o_mid_freq_internal_osc_en  = mf_en;
  assign o_high_freq_internal_osc_en = hf_en;
  assign o_low_freq_internal_osc_en  = man_en_q[`BIT_LF_ON - 2] || i_periph_req[2] ||
                                       (new_source_request_q == `SRC_LF);
  assign o_secondary_osc_en          = man_en_q[`BIT_SOSC_ON - 2] || i_periph_req[1] ||
                                       (new_source_request_q == `SRC_SOSC);
  assign o_converter_osc_en          = man_en_q[`BIT_ADC_ON - 2] || i_periph_req[0];
  assign o_secondary_osc_power_sel   = sosc_pwr_q;
  assign o_pll_en                    = (new_source_request_q == `SRC_PLL);
  assign o_source                    = new_source_request_q;
  assign o_divider                   = new_divider_request_q;
  assign o_hf_freq_code              = hf_freq_code_q;
  assign o_hf_tune                   = tune_now_q;
  assign o_hf_ready_flag             = hf_ready_q;
  assign o_mf_ready_flag             = hf_ready_q && mf_en;

  // Pin is free unless a crystal on the external pins is in use
  assign o_clkout      = clkout_div_q[1];
  assign o_clkout_oe_n = !(i_clock_out_enable_cfg && !(uses_ext && crystal_mode));

  // Read mux; unused upper bits read as zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (addr_q)
      `OFF_FREQ_SEL: rd_d[3:0] = hf_freq_code_q;
      `OFF_TUNE:     rd_d[5:0] = hf_tune_value_q;
      `OFF_MAN_EN:   rd_d[7:2] = man_en_q;
      `OFF_SRC_REQ:  rd_d[6:0] = {new_source_request_q, new_divider_request_q};
      `OFF_STATUS: begin
        rd_d[`ST_HF_READY]             = hf_ready_q;
        rd_d[`ST_MF_READY]             = hf_ready_q && mf_en;
        rd_d[`ST_HOLD]                 = o_run_hold;
        rd_d[`ST_PLL]                  = o_pll_en;
        rd_d[`ST_SRC_MSB:`ST_SRC_LSB]  = new_source_request_q;
      end
      `OFF_AUX:      rd_d[`BIT_SOSC_PWR] = sosc_pwr_q;
      default:       rd_d = 32'h0000_0000;
    endcase
  end

  // Bus slave: writes take zero wait, reads take one wait state
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 5'h00;
      o_hrdata  <= 32'h0000_0000;
    end else if (i_ce) begin
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        o_hrdata  <= rd_d;
      end else begin
        wr_pend_q <= addr_take && i_hwrite;
        rd_pend_q <= addr_take && !i_hwrite;
        if (addr_take) begin
          addr_q <= {i_haddr[4:2], 2'b00};
        end
      end
    end
  end

  // Register file, configuration load and oscillator state
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hf_freq_code_q        <= `RST_FREQ_4M;
      hf_tune_value_q       <= `RST_TUNE;
      man_en_q              <= `RST_MAN_EN;
      new_source_request_q  <= `SRC_HF;
      new_divider_request_q <= `DIV_1;
      sosc_pwr_q            <= 1'b0;
      tune_now_q            <= `RST_TUNE;
      tune_tmr_q            <= 8'h00;
      settle_q              <= 8'h00;
      hf_ready_q            <= 1'b0;
      cfg_load_q            <= 1'b1;
      clkout_div_q          <= 2'b00;
    end else if (i_ce) begin
      clkout_div_q <= clkout_div_q + 2'b01;
      cfg_load_q   <= 1'b0;
      if (cfg_load_q) begin
        // Catch the configuration after reset release
        hf_freq_code_q <= (i_reset_source_cfg == `SRC_HF64) ? `RST_FREQ_64M
                                                            : `RST_FREQ_4M;
        new_source_request_q  <= (i_reset_source_cfg == `SRC_HF64) ? `SRC_HF
                                                                   : i_reset_source_cfg;
        new_divider_request_q <= (i_reset_source_cfg == `SRC_HF) ? `DIV_4 : `DIV_1;
        settle_q   <= 8'h00;
        hf_ready_q <= 1'b0;
      end else if (wr_pend_q && !rd_pend_q) begin
        case (addr_q)
          `OFF_FREQ_SEL: begin
            if (i_hwdata[3:0] <= `FREQ_MAX_CODE) begin
              hf_freq_code_q <= i_hwdata[3:0];
              settle_q       <= 8'h00;
              hf_ready_q     <= 1'b0;
            end
          end
          `OFF_TUNE:   hf_tune_value_q <= i_hwdata[5:0];
          `OFF_MAN_EN: man_en_q        <= i_hwdata[7:2];
          `OFF_SRC_REQ: begin
            // Reserved source or divider codes leave both fields alone
            if ((wr_src == `SRC_EXT || wr_src == `SRC_HF || wr_src == `SRC_LF ||
                 wr_src == `SRC_SOSC || wr_src == `SRC_PLL) &&
                wr_div <= `DIV_MAX_CODE) begin
              new_source_request_q  <= wr_src;
              new_divider_request_q <= wr_div;
            end
          end
          `OFF_AUX:    sosc_pwr_q <= i_hwdata[`BIT_SOSC_PWR];
          default:     sosc_pwr_q <= sosc_pwr_q;
        endcase
      end else if (!hf_en) begin
        // A stopped oscillator is not ready; it settles afresh on restart
        settle_q   <= 8'h00;
        hf_ready_q <= 1'b0;
      end else if (!hf_ready_q) begin
        if (settle_q == `HF_SETTLE_CYC - 8'h01) begin
          hf_ready_q <= 1'b1;
        end
        settle_q <= settle_q + 8'h01;
      end
      // Walk the applied tune one step at a time toward the register
      if (tune_now_q != hf_tune_value_q) begin
        if (tune_tmr_q == `TUNE_STEP_CYC - 8'h01) begin
          tune_tmr_q <= 8'h00;
          if ($signed(tune_now_q) < $signed(hf_tune_value_q)) begin
            tune_now_q <= tune_now_q + 6'h01;
          end else begin
            tune_now_q <= tune_now_q - 6'h01;
          end
        end else begin
          tune_tmr_q <= tune_tmr_q + 8'h01;
        end
      end else begin
        tune_tmr_q <= 8'h00;
      end
    end
  end

  osc_startup_timer u_ost (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_start   (startup),
    // Crystal hold covers power-on load as well as wake
    .i_crystal (ost_crystal),
    .i_osc_in  (i_osc_in),
    .o_hold    (o_run_hold)
  );

  // Medium clocks stall at their level until HF is ready again
  mf_clock_divider u_mf (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .i_run      (mf_en && hf_ready_q),
    .i_tick     (i_hf_tick),
    .i_half_cnt (o_hf_freq_mhz),
    .o_mf_500k  (o_mf_500k),
    .o_mf_31k   (o_mf_31k)
  );
endmodule // oscillator_source_control
`default_nettype wire

// ### ext_osc_source_model.sv
// Behavioural crystal or external clock feeding the oscillator input
`timescale 1ns/1ns
`default_nettype none
module ext_osc_source_model (
  input  wire logic i_clk,
  input  wire logic i_run,
  output wire logic o_osc
);
  logic [1:0] phase_q = 2'h0;
  // Period of four clocks while enabled; stands still when not driven
  always @(posedge i_clk) begin
    if (i_run) begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign o_osc = phase_q[1];
endmodule // ext_osc_source_model
`default_nettype wire

// ### oscillator_source_control_monitor.sv
// Concurrent checks on the oscillator source control ports
`timescale 1ns/1ns
`default_nettype none
module oscillator_source_control_monitor (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_ce,
  input wire logic       i_wake,
  input wire logic [2:0] i_ext_osc_mode_cfg,
  input wire logic       i_clock_out_enable_cfg,
  input wire logic [5:0] i_periph_req,
  input wire logic       o_external_osc_en,
  input wire logic       o_pll_en,
  input wire logic [2:0] o_source,
  input wire logic [3:0] o_hf_freq_code,
  input wire logic [6:0] o_hf_freq_mhz,
  input wire logic [5:0] o_hf_tune,
  input wire logic       o_run_hold,
  input wire logic       o_clkout,
  input wire logic       o_clkout_oe_n
);
  localparam logic [6:0] mhz_table [0:8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h0C,
                                           7'h10, 7'h20, 7'h30, 7'h40};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  code_range_a: assert property (o_hf_freq_code <= 4'h8)
    else $error("frequency code outside legal range");
  code_decode_a: assert property (o_hf_freq_code <= 4'h8 |->
    o_hf_freq_mhz == mhz_table[o_hf_freq_code]) else $error("frequency decode wrong");
  tune_step_a: assert property ($changed(o_hf_tune) |->
    (o_hf_tune == $past(o_hf_tune) + 6'h01) || (o_hf_tune == $past(o_hf_tune) - 6'h01))
    else $error("tune moved by more than one step");
  pll_route_a: assert property (o_pll_en == (o_source == 3'h2))
    else $error("pll enable does not follow source");
  ext_request_a: assert property (i_periph_req[5] |-> o_external_osc_en)
    else $error("external oscillator request ignored");
  clkout_rate_a: assert property (disable iff (!i_nrst || !i_ce)
    $rose(o_clkout) |-> o_clkout ##1 o_clkout ##1 !o_clkout) else $error("clock out not quarter");
  clkout_off_a: assert property (!i_clock_out_enable_cfg |-> o_clkout_oe_n)
    else $error("clock out driven while disabled");
  clkout_on_a: assert property (i_clock_out_enable_cfg && o_source == 3'h6 |-> !o_clkout_oe_n)
    else $error("clock out not driven");
  ec_nohold_a: assert property (i_ce && i_wake && i_ext_osc_mode_cfg >= 3'h5
    |-> ##[1:2] !o_run_hold) else $error("hold in external clock mode");
  xtal_hold_a: assert property (i_ce && i_wake && i_ext_osc_mode_cfg <= 3'h2 &&
    (o_source == 3'h7 || o_source == 3'h2) |=> o_run_hold[*8]) else $error("crystal hold dropped");
  static_halt_a: assert property (!i_ce |=> $stable(o_hf_tune) && $stable(o_clkout)
    && $stable(o_source) && $stable(o_run_hold)) else $error("state moved while halted");
endmodule // oscillator_source_control_monitor
bind oscillator_source_control oscillator_source_control_monitor monitor (.*);
`default_nettype wire

// ### oscillator_source_control_test.sv
// Self-checking bench for the oscillator source control block
`timescale 1ns/1ns
`default_nettype none
`include "osc_consts.vh"
module oscillator_source_control_test;
  typedef struct packed { logic [7:0] man; logic [5:0] req; logic [5:0] en; } row_t;
  logic        i_clk = 1'b0, i_nrst = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        ck_en = 1'b1, wake = 1'b0, tick = 1'b0, hrdy, hresp, pll, hold;
  logic        clkout, oe_n, hf_rdy, mf_rdy, osc_in, spwr, m5, m3;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  rst_src = 3'h6, mode = 3'h7, src;
  logic [5:0]  req = 6'h00, en, tune;
  logic [3:0]  div, fcode;
  logic [6:0]  mhz;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [13:0] snap;
  logic        mf_last;
  int          cyc;
  int          fail_count = 0, check_count = 0;
  logic [6:0]  mhz_exp [0:8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h20, 7'h30, 7'h40};
  row_t        rows [8] = '{'{8'h80, 6'h00, 6'h30}, '{8'h40, 6'h00, 6'h10}, '{8'h20, 6'h00, 6'h18},
                            '{8'h10, 6'h00, 6'h14}, '{8'h08, 6'h00, 6'h12}, '{8'h04, 6'h00, 6'h11},
                            '{8'h00, 6'h3F, 6'h3F}, '{8'h03, 6'h00, 6'h10}};
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) tick <= ~tick;
  oscillator_source_control dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_reset_source_cfg(rst_src), .i_ext_osc_mode_cfg(mode), .i_clock_out_enable_cfg(ck_en),
    .i_wake(wake), .i_osc_in(osc_in), .i_hf_tick(tick), .i_periph_req(req),
    .o_external_osc_en(en[5]), .o_high_freq_internal_osc_en(en[4]),
    .o_mid_freq_internal_osc_en(en[3]), .o_low_freq_internal_osc_en(en[2]),
    .o_secondary_osc_en(en[1]), .o_converter_osc_en(en[0]), .o_secondary_osc_power_sel(spwr),
    .o_pll_en(pll), .o_source(src), .o_divider(div), .o_hf_freq_code(fcode),
    .o_hf_freq_mhz(mhz), .o_hf_tune(tune), .o_hf_ready_flag(hf_rdy), .o_mf_ready_flag(mf_rdy),
    .o_mf_500k(m5), .o_mf_31k(m3), .o_run_hold(hold), .o_clkout(clkout), .o_clkout_oe_n(oe_n));
  ext_osc_source_model xtal (.i_clk(i_clk), .i_run(en[5]), .o_osc(osc_in));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    rd = hrdata;
  endtask
  task automatic regs_chk(input logic [31:0] f, input logic [31:0] s);
    bus(1'b0, `OFF_FREQ_SEL, 32'h0);
    chk("freq reset", f, rd);
    bus(1'b0, `OFF_TUNE, 32'h0);
    chk("tune reset", 32'h0, rd);
    bus(1'b0, `OFF_MAN_EN, 32'h0);
    chk("enable reset", 32'h0, rd);
    bus(1'b0, `OFF_SRC_REQ, 32'h0);
    chk("source reset", s, rd);
    bus(1'b0, 32'h0000_001C, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("bus response", 32'h0, 32'(hresp));
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (rows[i]) begin
      req <= rows[i].req;
      bus(1'b1, `OFF_MAN_EN, 32'(rows[i].man));
      bus(1'b0, `OFF_MAN_EN, 32'h0);
      chk("enable reg", 32'(rows[i].man & 8'hFC), rd);
      chk("enables", 32'(rows[i].en), 32'(en));
    end
    for (int c = 0; c < 10; c++) begin
      bus(1'b1, `OFF_FREQ_SEL, 32'(c));
      bus(1'b0, `OFF_FREQ_SEL, 32'h0);
      chk("ready clear", 32'h0, 32'(hf_rdy));
      chk("freq code", (c > 8) ? 32'h8 : 32'(c), rd);
      chk("freq mhz", 32'(mhz_exp[(c > 8) ? 8 : c]), 32'(mhz));
    end
    repeat (70) @(posedge i_clk);
    chk("ready set", 32'h1, 32'(hf_rdy));
    bus(1'b1, `OFF_MAN_EN, 32'h20);
    bus(1'b0, `OFF_STATUS, 32'h0);
    chk("status", 32'hCC, rd);
    chk("mf ready", 32'h1, 32'(mf_rdy));
    bus(1'b1, `OFF_AUX, 32'h40);
    bus(1'b0, `OFF_AUX, 32'h0);
    chk("aux reg", 32'h40, rd);
    chk("power sel", 32'h1, 32'(spwr));
    // Second of two waits spans one full half period of each medium clock
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 2; k++) begin
        mf_last = s ? m3 : m5;
        cyc = 0;
        while ((s ? m3 : m5) === mf_last && cyc < 5000) begin
          @(posedge i_clk);
          cyc++;
        end
      end
      chk(s ? "mf31 half" : "mf500 half", s ? 32'h800 : 32'h80, 32'(cyc));
    end
    bus(1'b1, `OFF_TUNE, 32'hFFFF_FFE0);
    bus(1'b0, `OFF_TUNE, 32'h0);
    chk("tune reg", 32'h20, rd);
    repeat (600) @(posedge i_clk);
    chk("tune applied", 32'h20, 32'(tune));
    bus(1'b1, `OFF_SRC_REQ, 32'h23);
    bus(1'b1, `OFF_SRC_REQ, 32'h30);
    bus(1'b1, `OFF_SRC_REQ, 32'h7A);
    chk("pll source", 32'h14, {27'h0, pll, src, 1'b0});
    chk("divider", 32'h3, 32'(div));
    bus(1'b1, `OFF_SRC_REQ, 32'h70);
    mode <= 3'h1;
    bus(1'b1, `OFF_MAN_EN, 32'h80);
    chk("pin used", 32'h1, 32'(oe_n));
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    repeat (4000) @(posedge i_clk);
    chk("crystal hold", 32'h1, 32'(hold));
    repeat (200) @(posedge i_clk);
    chk("crystal release", 32'h0, 32'(hold));
    mode <= 3'h7;
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("ec no hold", 32'h0, 32'(hold));
    chk("pin free", 32'h0, 32'(oe_n));
    ce <= 1'b0;
    @(posedge i_clk);
    snap = {clkout, tune, fcode, src};
    repeat (20) @(posedge i_clk);
    chk("halted state", 32'(snap), 32'({clkout, tune, fcode, src}));
    ce <= 1'b1;
    rst_src <= 3'h0;
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    regs_chk(32'h8, 32'h60);
    end_sim();
  end
endmodule // oscillator_source_control_test
`default_nettype wire
